//--- dv/irs_chan_model.sv
`timescale 1ns/1ps
module irs_chan_model
    import irs_pkg::*;
(
    input  wire logic       pclk,     // Clock
    input  wire logic       presetn,  // Reset, active low
    input  wire irs_chan_s  chan,     // Interrupt from device
    input  wire logic [2:0] lat,      // Cycles before accepting
    output logic            intr_ack, // Accept pulse
    output logic [2:0]      got_cc,   // Accepted code
    output logic [15:0]     got_idw,  // Accepted word
    output int              acks      // Acceptances so far
);
    logic [2:0] cnt;

    // Accept a pending request after lat cycles, one-cycle pulse
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            intr_ack <= 1'b0;
            cnt      <= 3'h0;
            acks     <= 0;
            got_cc   <= 3'h0;
            got_idw  <= 16'h0000;
        end
        else if (intr_ack)
        begin
            intr_ack <= 1'b0;
            cnt      <= 3'h0;
        end
        else if (chan.req && cnt >= lat)
        begin
            intr_ack <= 1'b1;
            got_cc   <= chan.cc;
            got_idw  <= chan.idw;
            acks     <= acks + 1;
        end
        else
            cnt <= chan.req ? cnt + 3'h1 : 3'h0;
endmodule

//--- dv/irs_reporter_bench.sv
`timescale 1ns/1ps
`define CHK(g, x) begin compares++; if ((g) !== (x)) begin num_errors++; \
    $display("unexpected t=%0t got %h exp %h", $time, g, x); end end
module irs_reporter_bench
    import irs_pkg::*;
;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0;
    logic        pwrite = 0, status_rd = 0, ev, cs_m = 0;
    logic        pready, pslverr, op_end, skip_fetch, blk_drive, intr_ack;
    logic [7:0]  paddr = 8'h00, dev_addr = 8'h00, dv;
    logic [31:0] pwdata = 32'h0, prdata, rv;
    logic [2:0]  lat = 3'h0, got_cc;
    logic [15:0] status_word, got_idw;
    irs_evt_s    evt = '0, e;
    irs_chan_s   chan;
    int          num_errors = 0, compares = 0, acks, cyc = 0, k;
    integer      seed = 32'h9a3b;

    always #5 pclk = ~pclk;

    irs_reporter irs_reporter_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .evt(evt), .status_rd(status_rd),
        .status_word(status_word), .intr_ack(intr_ack), .chan(chan),
        .op_end(op_end), .skip_fetch(skip_fetch), .blk_drive(blk_drive));
    irs_chan_model irs_chan_model_i (.pclk(pclk), .presetn(presetn),
        .chan(chan), .lat(lat), .intr_ack(intr_ack), .got_cc(got_cc),
        .got_idw(got_idw), .acks(acks));

    ////////////////////////////////////////
    task end_of_test();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // One APB transfer; read data and error taken at the ready edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rdc(input logic [7:0] a, input logic [31:0] x, input logic xe);
        apb(1'b0, a, 32'h0);
        `CHK(rv, x)
        `CHK(ev, xe)
    endtask

    // Mode bits: [2] single meaning, [1] suppress, [0] cycle steal
    task set_ctrl(input logic [2:0] m);
        dev_addr = 8'($random(seed));
        cs_m = m[0];
        apb(1'b1, 8'h00, {16'h0, dev_addr, 5'h0, m});
        rdc(8'h00, {16'h0, dev_addr, 5'h0, m}, 1'b0);
    endtask

    // Pulse events, let the channel accept, compare what it took
    task fire(input irs_evt_s x, input logic [2:0] c, input logic [7:0] i);
        int a0;
        int n;
        a0 = acks;
        @(posedge pclk);
        evt <= x;
        lat <= 3'($random(seed));
        @(posedge pclk);
        `CHK(blk_drive, cs_m & x.stor_parity)
        evt <= '0;
        for (n = 0; n < 64 && acks == a0; n++)
            @(posedge pclk);
        `CHK(got_cc, c)
        `CHK(got_idw, {i, dev_addr})
    endtask

    // Status byte of a device without cycle steal
    function logic [7:0] ncs(irs_evt_s x, logic single);
        logic [7:0] b;
        b = {x.status_avail, x.cmd_reject, x.dev_bits};
        return (b == 8'h00 && !single) ? 8'h80 : b;
    endfunction

    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            num_errors++;
            end_of_test();
        end
    end

    ////////////////////////////////////////
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rdc(8'h00, 32'h0, 1'b0);
        rdc(8'h08, 32'h0, 1'b0);
        rdc(8'h0c, 32'h0, 1'b0);
        rdc(8'h10, 32'h0, 1'b1);
        apb(1'b1, 8'h08, 32'hffff);
        `CHK(ev, 1'b1)
        // Each cycle-steal error bit alone, attention at random
        for (k = 0; k < 8; k++)
        begin
            set_ctrl(3'h1);
            e = '0;
            e[26 - k] = 1'b1;
            e.attention = 1'($random(seed));
            fire(e, e.attention ? 3'h6 : 3'h2, 8'h80 >> k);
        end
        // Several errors reported together
        repeat (4)
        begin
            e = '0;
            dv = 8'($random(seed)) | 8'h01;
            e[26:19] = dv;
            fire(e, 3'h2, dv);
        end
        // No cycle steal: extra status, reject, device bits
        set_ctrl(3'h0);
        repeat (6)
        begin
            e = '0;
            e.status_avail = 1'($random(seed));
            e.cmd_reject = 1'($random(seed));
            e.dev_bits = 6'($random(seed));
            e.exception = 1'b1;
            fire(e, 3'h2, ncs(e, 1'b0));
        end
        e = '0;
        e.exception = 1'b1;
        fire(e, 3'h2, 8'h80);
        set_ctrl(3'h4);
        fire(e, 3'h2, 8'h00);
        // Codes other than exception
        e = '0;
        e.ctl_end = 1'b1;
        fire(e, 3'h0, 8'h00);
        e = '0;
        e.pci = 1'b1;
        e.pci_id = 8'($random(seed));
        e.attention = 1'($random(seed));
        fire(e, e.attention ? 3'h5 : 3'h1, e.pci_id);
        dv = 8'($random(seed));
        apb(1'b1, 8'h04, {24'h0, dv});
        rdc(8'h04, {24'h0, dv}, 1'b0);
        e = '0;
        e.attention = 1'b1;
        fire(e, 3'h4, dv);
        e = '0;
        e.norm_end = 1'b1;
        e.attention = 1'($random(seed));
        fire(e, e.attention ? 3'h7 : 3'h3, {1'b0, dv[6:0]});
        // Suppressed length error, then a normal end
        set_ctrl(3'h3);
        e = '0;
        e.len_err = 1'b1;
        @(posedge pclk);
        evt <= e;
        @(posedge pclk);
        evt <= '0;
        e = '0;
        e.norm_end = 1'b1;
        fire(e, 3'h3, {1'b1, dv[6:0]});
        // Status transfer while an error waits for acceptance
        e = '0;
        e.dcb_err = 1'b1;
        @(posedge pclk);
        evt <= e;
        lat <= 3'h7;
        @(posedge pclk);
        evt <= '0;
        status_rd <= 1'b1;
        @(posedge pclk);
        status_rd <= 1'b0;
        @(posedge pclk);
        `CHK(status_word, {8'h10, dev_addr})
        repeat (12) @(posedge pclk);
        `CHK(got_cc, 3'h2)
        `CHK(got_idw, {8'h10, dev_addr})
        // Status transfer after acceptance
        @(posedge pclk);
        status_rd <= 1'b1;
        @(posedge pclk);
        status_rd <= 1'b0;
        repeat (2) @(posedge pclk);
        `CHK(status_word, {8'h00, dev_addr})
        apb(1'b0, 8'h08, 32'h0);
        `CHK(rv[15:8], 8'h00)
        end_of_test();
    end
endmodule

//--- dv/irs_reporter_sva.sv
`timescale 1ns/1ps
module irs_reporter_sva
    import irs_pkg::*;
(
    input wire logic        pclk,        // Clock
    input wire logic        presetn,     // Reset, active low
    input wire logic        psel,        // APB select
    input wire logic        penable,     // APB access
    input wire logic        pwrite,      // APB write
    input wire logic [7:0]  paddr,       // APB address
    input wire logic [31:0] pwdata,      // APB write data
    input wire logic [31:0] prdata,      // APB read data
    input wire logic        pready,      // APB ready
    input wire logic        pslverr,     // APB error
    input wire irs_evt_s    evt,         // Device events
    input wire logic        status_rd,   // Status request
    input wire logic [15:0] status_word, // Status word
    input wire logic        intr_ack,    // Channel accept
    input wire irs_chan_s   chan,        // Interrupt toward channel
    input wire logic        op_end,      // Terminate
    input wire logic        skip_fetch,  // No block fetch
    input wire logic        blk_drive    // Keep data off bus
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////
    // Bus and interrupt relations
    a_apb_no_wait: assert property (psel && penable |-> pready)
        else $error("access phase without ready");
    a_unmapped_err: assert property (psel && penable && (paddr > 8'h0c
        || (pwrite && paddr >= 8'h08)) |-> pslverr)
        else $error("bad access not flagged");
    a_ack_drops_req: assert property (chan.req && intr_ack |=> !chan.req)
        else $error("request stands after acceptance");
    a_word_held: assert property (chan.req && !intr_ack |=> chan.req
        && $stable(chan.cc) && $stable(chan.idw))
        else $error("word changed before acceptance");
    a_cc0_zero: assert property (chan.req && chan.cc == 3'h0
        |-> chan.idw[15:8] == 8'h00)
        else $error("controller end with info byte");
    a_reject_ends: assert property (evt.cmd_reject |=> op_end)
        else $error("reject did not end operation");
    a_reject_skip: assert property (skip_fetch |-> $past(evt.cmd_reject))
        else $error("fetch skipped without reject");
    a_parity_hold: assert property (blk_drive |-> evt.stor_parity)
        else $error("data held off without parity error");
    a_err_req: assert property (evt.cmd_reject && !chan.req
        |-> ##[1:4] chan.req)
        else $error("error raised no interrupt");

    c_exc_ack: cover property (chan.req && intr_ack && chan.cc == 3'h2);
    c_att_pci: cover property (chan.req && chan.cc == 3'h5);
    c_err: cover property (pslverr);
    c_skip: cover property (skip_fetch);
endmodule

bind irs_reporter irs_reporter_sva irs_reporter_sva_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .evt(evt), .status_rd(status_rd),
    .status_word(status_word), .intr_ack(intr_ack), .chan(chan),
    .op_end(op_end), .skip_fetch(skip_fetch), .blk_drive(blk_drive));

//--- shared/irs_consts.svh
`ifndef IRS_CONSTS_SVH
`define IRS_CONSTS_SVH
// Register byte offsets
`define IRS_OFS_CTRL     8'h00
`define IRS_OFS_DEVINFO  8'h04
`define IRS_OFS_STATUS   8'h08
`define IRS_OFS_IDWORD   8'h0c
// Control register fields
`define IRS_CTRL_CS      0
`define IRS_CTRL_SUPP    1
`define IRS_CTRL_SINGLE  2
`define IRS_CTRL_ADDR_LO 8
`define IRS_CTRL_ADDR_HI 15
// Status register fields
`define IRS_ST_REQ       0
`define IRS_ST_SUPP      1
`define IRS_ST_CC_LO     4
`define IRS_ST_CC_HI     6
`define IRS_ST_ISB_LO    8
`define IRS_ST_ISB_HI    15
// Status byte bits, bit 0 is the most significant
`define IRS_ISB_B0       7
`define IRS_ISB_B1       6
`define IRS_ISB_B2       5
`define IRS_ISB_B3       4
`define IRS_ISB_B4       3
`define IRS_ISB_B5       2
`define IRS_ISB_B6       1
`define IRS_ISB_B7       0
// Reset values
`define IRS_CTRL_RST     32'h0000_0000
`define IRS_DEVINFO_RST  8'h00
// Interrupt condition codes
`define IRS_CC_CTL_END   3'h0
`define IRS_CC_PCI       3'h1
`define IRS_CC_EXC       3'h2
`define IRS_CC_DEV_END   3'h3
`define IRS_CC_ATTN      3'h4
`define IRS_CC_ATTN_PCI  3'h5
`define IRS_CC_ATTN_EXC  3'h6
`define IRS_CC_ATTN_END  3'h7
`endif

//--- shared/irs_pkg.sv
package irs_pkg;

    // Events raised by the device's operation logic
    typedef struct packed {
        logic       start;        // Start command accepted
        logic       status_avail; // Extra status readable
        logic       cmd_reject;   // Delayed command reject
        logic       len_err;      // Count / record length mismatch
        logic       dcb_err;      // Bad control block parameter
        logic       stor_parity;  // Bad storage parity on output
        logic       bad_addr;     // Address beyond storage
        logic       key_err;      // Wrong address key
        logic       bus_parity;   // Bus parity, channel or device
        logic       exception;    // Exception with no own bit
        logic [5:0] dev_bits;     // Device-specific status bits
        logic       pci;          // Control block asked for PCI
        logic [7:0] pci_id;       // Identifier of that block
        logic       attention;    // External event
        logic       norm_end;     // Operation ended normally
        logic       ctl_end;      // Controller became free
    } irs_evt_s;

    // Interrupt presentation toward the channel
    typedef struct packed {
        logic        req; // Interrupt request
        logic [2:0]  cc;  // Interrupt condition code
        logic [15:0] idw; // Identification word
    } irs_chan_s;

    typedef enum logic {
        IRS_IDLE = 1'b0,
        IRS_WAIT = 1'b1
    } irs_state_e;

endpackage

//--- src/irs_reporter.sv
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ps
`include "irs_consts.svh"
// What this block does
// R1 - Sends status for reads, residuals and interrupts
// R2 - Presents 16-bit identification word on acceptance
// R3 - High byte is info byte, status for 2/6
// R4 - Low byte carries the device address
// R5 - Condition code 0 gives zero info byte
// R6 - Codes 1/5 carry the control block identifier
// R7 - Codes 3/7 may flag suppression in bit 0
// R8 - Code 4 info byte is device-specific
// R9 - Status byte cleared once interrupt is accepted
// R10 - Never report zero status byte, one exception
// R11 - Non-stealing bit 0 flags extra status
// R12 - Non-stealing bit 1 command reject ends operation
// R13 - Stealing bit 0 extra status ends operation
// R14 - Bit 0 alone: residual word device-defined
// R15 - Reject in bit 1 skips block fetch, with cycle steal only
// R16 - Length mismatch bit 2, not when suppressed
// R17 - Bad block parameters set bit 3
// R18 - Storage parity bit 4, data not driven
// R19 - Bad address bit 5 ends cycle steal
// R20 - Wrong address key sets bit 6
// R21 - Bus parity sets bit 7, ends operation
// R22 - Three-bit condition code reported with word
// R23 - Suppressed exception then normal end sets bit 0
// R24 - Word and code held until acceptance
module irs_reporter
    import irs_pkg::*;
(
    input  wire logic        pclk,        // Bus clock, 100 MHz
    input  wire logic        presetn,     // Async reset, active low
    input  wire logic        psel,        // APB select
    input  wire logic        penable,     // APB access phase
    input  wire logic        pwrite,      // APB write
    input  wire logic [7:0]  paddr,       // APB byte address
    input  wire logic [31:0] pwdata,      // APB write data
    output logic      [31:0] prdata,      // APB read data
    output logic             pready,      // APB ready
    output logic             pslverr,     // APB error
    input  wire irs_evt_s    evt,         // Device events, pulses
    input  wire logic        status_rd,   // Status transfer request
    output logic      [15:0] status_word, // Status transfer word
    input  wire logic        intr_ack,    // Channel accepts interrupt
    output irs_chan_s        chan,        // Interrupt presentation
    output logic             op_end,      // Terminate operation
    output logic             skip_fetch,  // Do not fetch block
    output logic             blk_drive    // Keep data off the bus
);

    ////////////////////////////////////////////////////////////////////
    // Declarations

    irs_state_e  st_r;
    irs_state_e  st_nxt;
    logic [31:0] ctrl_r;
    logic [31:0] ctrl_nxt;
    logic [7:0]  devinfo_r;
    logic [7:0]  devinfo_nxt;
    logic [2:0]  cc_r;
    logic [2:0]  cc_nxt;
    logic [15:0] idw_r;
    logic [15:0] idw_nxt;
    logic [7:0]  pci_id_r;
    logic [7:0]  pci_id_nxt;
    logic        supp_r;
    logic        supp_nxt;
    logic        op_end_r;
    logic        op_end_nxt;
    logic        skip_r;
    logic        skip_nxt;
    logic [15:0] stw_r;
    logic [15:0] stw_nxt;
    logic [7:0]  isb_set;
    logic [7:0]  isb_clr;
    logic [7:0]  isb_q;
    logic [4:0]  cause_set;
    logic [4:0]  cause_clr;
    logic [4:0]  cause_q;
    logic [7:0]  info;
    logic [7:0]  isb_rep;
    logic [2:0]  cc_sel;
    logic        cs_mode;
    logic        supp_on;
    logic        allow_zero;
    logic [7:0]  dev_addr;
    logic        launch;
    logic        wr_en;
    logic        rd_en;
    logic        hit;

    assign cs_mode    = ctrl_r[`IRS_CTRL_CS];
    assign supp_on    = ctrl_r[`IRS_CTRL_SUPP];
    assign allow_zero = ~cs_mode & ctrl_r[`IRS_CTRL_SINGLE];
    assign dev_addr   = ctrl_r[`IRS_CTRL_ADDR_HI:`IRS_CTRL_ADDR_LO];

    ////////////////////////////////////////////////////////////////////
    // Decode of a register offset, used for reads
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == `IRS_OFS_CTRL) || (a == `IRS_OFS_DEVINFO) ||
                    (a == `IRS_OFS_STATUS) || (a == `IRS_OFS_IDWORD);
    endfunction

    // Writable offsets only
    function automatic logic is_rw(input logic [7:0] a);
        is_rw = (a == `IRS_OFS_CTRL) || (a == `IRS_OFS_DEVINFO);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Error events mapped onto the status byte
    always_comb
    begin
        isb_set = 8'h00;
        isb_set[`IRS_ISB_B0] = evt.status_avail;              // R11 R13
        isb_set[`IRS_ISB_B1] = evt.cmd_reject;                // R12 R15
        if (cs_mode)
        begin
            isb_set[`IRS_ISB_B2] = evt.len_err & ~supp_on;    // R16
            isb_set[`IRS_ISB_B3] = evt.dcb_err;               // R17
            isb_set[`IRS_ISB_B4] = evt.stor_parity;           // R18
            isb_set[`IRS_ISB_B5] = evt.bad_addr;              // R19
            isb_set[`IRS_ISB_B6] = evt.key_err;               // R20
            isb_set[`IRS_ISB_B7] = evt.bus_parity;            // R21
        end
        else
        begin
            isb_set[5:0] = evt.dev_bits;                      // R12
        end
    end

    // Status byte flags; several may stand at once
    irs_sticky #(
        .W(8)
    ) u_isb (
        .clk   (pclk),
        .rst_n (presetn),
        .set   (isb_set),
        .clr   (isb_clr),
        .q     (isb_q)
    );

    ////////////////////////////////////////////////////////////////////
    // Interrupt causes: {ctl_end, exception, pci, attention, end}
    always_comb
    begin
        cause_set = {evt.ctl_end,
                     (|isb_set) | evt.exception,
                     evt.pci,
                     evt.attention,
                     evt.norm_end};
    end

    irs_sticky #(
        .W(5)
    ) u_cause (
        .clk   (pclk),
        .rst_n (presetn),
        .set   (cause_set),
        .clr   (cause_clr),
        .q     (cause_q)
    );

    ////////////////////////////////////////////////////////////////////
    // Condition code and information byte from the pending causes
    always_comb
    begin
        isb_rep = isb_q;
        if (isb_q == 8'h00 && !allow_zero)
            isb_rep[`IRS_ISB_B0] = 1'b1;                      // R10
        if (cause_q[3])
        begin
            cc_sel = cause_q[1] ? `IRS_CC_ATTN_EXC : `IRS_CC_EXC;
            info   = isb_rep;                                 // R3
        end
        else if (cause_q[2])
        begin
            cc_sel = cause_q[1] ? `IRS_CC_ATTN_PCI : `IRS_CC_PCI;
            info   = pci_id_r;                                // R6
        end
        else if (cause_q[0])
        begin
            cc_sel = cause_q[1] ? `IRS_CC_ATTN_END : `IRS_CC_DEV_END;
            info   = {supp_r & supp_on, devinfo_r[6:0]};      // R7 R23
        end
        else if (cause_q[1])
        begin
            cc_sel = `IRS_CC_ATTN;
            info   = devinfo_r;                               // R8
        end
        else
        begin
            cc_sel = `IRS_CC_CTL_END;
            info   = 8'h00;                                   // R5
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Presentation sequence: latch, hold, release on acceptance
    always_comb
    begin
        st_nxt    = st_r;
        cc_nxt    = cc_r;
        idw_nxt   = idw_r;
        isb_clr   = 8'h00;
        cause_clr = 5'h00;
        launch    = (st_r == IRS_IDLE) && (|cause_q);
        unique case (st_r)
            IRS_IDLE:
            begin
                if (launch)
                begin
                    st_nxt  = IRS_WAIT;
                    cc_nxt  = cc_sel;                         // R22
                    idw_nxt = {info, dev_addr};               // R2 R4
                end
            end
            IRS_WAIT:
            begin
                if (intr_ack)
                begin
                    st_nxt    = IRS_IDLE;
                    isb_clr   = isb_q;                        // R9
                    cause_clr = cause_q;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r  <= IRS_IDLE;
            cc_r  <= 3'h0;
            idw_r <= 16'h0000;
        end
        else
        begin
            st_r  <= st_nxt;                                  // R24
            cc_r  <= cc_nxt;
            idw_r <= idw_nxt;
        end
    end

    assign chan.req = (st_r == IRS_WAIT);
    assign chan.cc  = cc_r;
    assign chan.idw = idw_r;

    ////////////////////////////////////////////////////////////////////
    // Side state: block identifier, suppression memory, terminations
    always_comb
    begin
        pci_id_nxt = evt.pci ? evt.pci_id : pci_id_r;
        supp_nxt   = supp_r;
        if (evt.start || (intr_ack && st_r == IRS_WAIT && cause_q[0]))
            supp_nxt = 1'b0;
        if (evt.len_err && supp_on)
            supp_nxt = 1'b1;                                  // R23
        // Any error flag ends the work; plain extra status only with cycle steal
        op_end_nxt = (|isb_set[6:0]) | (cs_mode & isb_set[7]); // R12 R13 R21
        skip_nxt   = cs_mode & evt.cmd_reject;                // R15
        stw_nxt    = status_rd ? {isb_q, dev_addr} : stw_r;   // R1 R14
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pci_id_r <= 8'h00;
            supp_r   <= 1'b0;
            op_end_r <= 1'b0;
            skip_r   <= 1'b0;
            stw_r    <= 16'h0000;
        end
        else
        begin
            pci_id_r <= pci_id_nxt;
            supp_r   <= supp_nxt;
            op_end_r <= op_end_nxt;
            skip_r   <= skip_nxt;
            stw_r    <= stw_nxt;
        end
    end

    assign op_end      = op_end_r;
    assign skip_fetch  = skip_r;
    assign status_word = stw_r;
    // Bad-parity data must never reach the bus, so no flop here
    assign blk_drive   = cs_mode & evt.stor_parity;           // R18

    ////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states, error on unmapped or read-only write
    assign wr_en   = psel & penable & pwrite;
    assign rd_en   = psel & penable & ~pwrite;
    assign hit     = pwrite ? is_rw(paddr) : is_mapped(paddr);
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit;

    always_comb
    begin
        ctrl_nxt    = ctrl_r;
        devinfo_nxt = devinfo_r;
        if (wr_en && paddr == `IRS_OFS_CTRL)
            ctrl_nxt = {16'h0000, pwdata[15:8], 5'h00, pwdata[2:0]};
        if (wr_en && paddr == `IRS_OFS_DEVINFO)
            devinfo_nxt = pwdata[7:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r    <= `IRS_CTRL_RST;
            devinfo_r <= `IRS_DEVINFO_RST;
        end
        else
        begin
            ctrl_r    <= ctrl_nxt;
            devinfo_r <= devinfo_nxt;
        end
    end

    // Read data mux; unmapped reads return zero
    always_comb
    begin
        prdata = 32'h0000_0000;
        if (rd_en)
        begin
            unique case (paddr)
                `IRS_OFS_CTRL:    prdata = ctrl_r;
                `IRS_OFS_DEVINFO: prdata = {24'h000000, devinfo_r};
                `IRS_OFS_STATUS:
                begin
                    prdata[`IRS_ST_REQ]  = chan.req;
                    prdata[`IRS_ST_SUPP] = supp_r;
                    prdata[`IRS_ST_CC_HI:`IRS_ST_CC_LO]   = cc_r;
                    prdata[`IRS_ST_ISB_HI:`IRS_ST_ISB_LO] = isb_q;
                end
                `IRS_OFS_IDWORD:  prdata = {16'h0000, idw_r};
                default:          prdata = 32'h0000_0000;
            endcase
        end
    end

endmodule

//--- src/irs_sticky.sv
`timescale 1ns/1ps
module irs_sticky #(
    parameter int W = 8
) (
    input  wire logic         clk,   // Clock
    input  wire logic         rst_n, // Async reset, active low
    input  wire logic [W-1:0] set,   // Set pulses
    input  wire logic [W-1:0] clr,   // Clear pulses
    output logic      [W-1:0] q      // Sticky flags
);

    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;

    ////////////////////////////////////////////////////////////////////
    // One flag per bit, a set in the clear cycle wins
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            always_comb
            begin
                q_nxt[i] = set[i] | (q_r[i] & ~clr[i]);
            end

            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    q_r[i] <= 1'b0;
                else
                    q_r[i] <= q_nxt[i];
            end
        end
    endgenerate

    assign q = q_r;

endmodule
